/* rtl/pirs_periph_irq.sv */
// Peripheral interrupt flags, reset-cause status and an APB register slave
module pirs_periph_irq
    import pirs_pkg::*;
(
    // APB slave
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // Peripheral events and levels, same clock domain
    input  wire pirs_events_t events,
    input  wire pirs_usart_t  usart,
    input  wire pirs_cc_mode_t capcomp1_mode,
    input  wire logic [7:0]   timer8_count,
    input  wire logic [7:0]   timer8_period,
    // Reset causes, held across the core reset (pins from the reset block)
    input  wire logic         por_n,
    input  wire logic         brownout_reset,
    input  wire logic         brownout_detect_enable,
    // Interrupt outputs
    output logic              periph_irq_req,
    output logic              irq
);

    logic [7:0]  flags_1;
    logic        capcomp2_flag;
    logic [7:0]  enable_1;
    logic        capcomp2_enable;
    logic [1:0]  cause;
    logic [3:0]  irq_status;
    logic [3:0]  irq_enable;
    logic        global_irq_enable;
    logic        bor_meta;
    logic        bor_sync;
    logic        bor_seen;
    logic        match_prev;
    logic        rx_meta;
    logic        rx_sync;
    logic        tx_meta;
    logic        tx_sync;

    logic        acc;
    logic        take;
    logic        wr;
    logic [7:0]  idx;
    logic        mapped;
    logic        refuse;
    logic [7:0]  wbyte;
    logic [7:0]  set_1;
    logic        period_match;
    logic        bor_edge;
    logic [3:0]  next_ev;
    logic        periph_pending;
    logic        next_req;
    logic        next_irq;
    logic [31:0] next_rdata;

    // Write strobes, one per writable register
    logic        wr_flags_1;
    logic        wr_flags_2;
    logic        wr_enable_1;
    logic        wr_enable_2;
    logic        wr_cause;
    logic        wr_irq_enable;
    logic        wr_irq_clear;
    logic        wr_config;

    // Register index match, gated by a strobe
    function automatic logic hit(input logic strobe, input logic [7:0] at, input logic [7:0] target);
        return strobe && (at == target);
    endfunction

    // Unit 1 flag source follows its mode; PWM and off raise nothing
    function automatic logic cc1_event(input pirs_cc_mode_t mode, input logic capture, input logic match);
        case (mode)
            PIRS_CC_CAPTURE: return capture;
            PIRS_CC_COMPARE: return match;
            default:         return 1'b0;
        endcase
    endfunction

    assign acc   = psel && penable;
    // Pending access phase, answered at the next edge
    assign take  = acc && !pready;
    // Write lands at the pready edge only; a second write would wipe a fresh flag
    assign wr    = acc && pwrite && pready;
    assign idx   = paddr[9:2];
    assign wbyte = pwdata[7:0];

    assign wr_flags_1    = hit(wr, idx, IDX_FLAGS_1);
    assign wr_flags_2    = hit(wr, idx, IDX_FLAGS_2);
    assign wr_enable_1   = hit(wr, idx, IDX_ENABLE_1);
    assign wr_enable_2   = hit(wr, idx, IDX_ENABLE_2);
    assign wr_cause      = hit(wr, idx, IDX_RESET_CAUSE);
    assign wr_irq_enable = hit(wr, idx, IDX_IRQ_ENABLE);
    assign wr_irq_clear  = hit(wr, idx, IDX_IRQ_CLEAR);
    assign wr_config     = hit(wr, idx, IDX_CONFIG);

    // Edge on equality so a stalled timer does not re-set the flag every cycle
    assign period_match = (timer8_count == timer8_period);

    // Hardware set terms, independent of every enable
    always_comb begin
        set_1 = 8'h00;
        set_1[BIT_PARALLEL]  = events.parallel_done;
        set_1[BIT_SYNC_SER]  = events.sync_serial_done;
        set_1[BIT_CAPCOMP1]  = cc1_event(capcomp1_mode, events.capture1, events.compare1_match);
        set_1[BIT_PERIOD]    = period_match && !match_prev;
        set_1[BIT_TMR16_OVF] = events.timer16_overflow;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_prev <= 1'b0;
        end else begin
            match_prev <= period_match;
        end
    end

    // USART levels are treated as external and synchronised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
        end else begin
            rx_meta <= usart.rx_full;
            rx_sync <= rx_meta;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_meta <= 1'b0;
            tx_sync <= 1'b0;
        end else begin
            tx_meta <= usart.tx_full;
            tx_sync <= tx_meta;
        end
    end

    // Sticky flags except the RX/TX buffer bits, which follow the synchronised levels; a set in the cycle of a software clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_1 <= FLAGS_RESET;
        end else begin
            if (wr_flags_1) begin
                flags_1 <= ((flags_1 & ~FLAGS_1_WMASK) | (wbyte & FLAGS_1_WMASK)) | set_1;
            end else begin
                flags_1 <= flags_1 | set_1;
            end
            flags_1[BIT_RX_BUF] <= rx_sync;
            flags_1[BIT_TX_BUF] <= tx_sync;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capcomp2_flag <= 1'b0;
        end else if (wr_flags_2) begin
            capcomp2_flag <= wbyte[BIT_CAPCOMP2] | events.capcomp2_event;
        end else begin
            capcomp2_flag <= capcomp2_flag | events.capcomp2_event;
        end
    end

    // Enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_1 <= ENABLE_RESET;
        end else if (wr_enable_1) begin
            enable_1 <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capcomp2_enable <= 1'b0;
        end else if (wr_enable_2) begin
            capcomp2_enable <= wbyte[BIT_CAPCOMP2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable <= 1'b0;
        end else if (wr_config) begin
            global_irq_enable <= wbyte[0];
        end
    end

    // Brown-out pulse comes from the supply monitor; synchronise it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bor_meta <= 1'b0;
            bor_sync <= 1'b0;
        end else begin
            bor_meta <= brownout_reset;
            bor_sync <= bor_meta;
        end
    end

    // Previous synchronised level, for the rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bor_seen <= 1'b0;
        end else begin
            bor_seen <= bor_sync;
        end
    end

    assign bor_edge = bor_sync && !bor_seen;

    // Reset cause lives on the power-on reset only, so a core reset keeps it
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            cause <= CAUSE_RESET;
        end else if (bor_edge && brownout_detect_enable) begin
            cause[BIT_BROWNOUT] <= 1'b0;
        end else if (wr_cause) begin
            cause <= wbyte[1:0] & RESET_CAUSE_MASK[1:0];
        end
    end

    // Summary interrupt: sticky status, write-one-to-clear, set wins
    assign periph_pending = |(flags_1 & enable_1) | (capcomp2_flag & capcomp2_enable);

    always_comb begin
        next_ev = 4'h0;
        next_ev[EV_FLAGS_1]  = |set_1;
        next_ev[EV_FLAGS_2]  = events.capcomp2_event;
        next_ev[EV_BROWNOUT] = bor_edge;
        // Set on a flags_1 bit already pending: software missed one event
        next_ev[EV_OVERRUN]  = |(set_1 & flags_1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= IRQ_RESET;
        end else if (wr_irq_clear) begin
            irq_status <= (irq_status & ~wbyte[3:0]) | next_ev;
        end else begin
            irq_status <= irq_status | next_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= IRQ_RESET;
        end else if (wr_irq_enable) begin
            irq_enable <= wbyte[3:0];
        end
    end

    assign mapped = (idx == IDX_FLAGS_1) || (idx == IDX_FLAGS_2) || (idx == IDX_ENABLE_1)
                 || (idx == IDX_ENABLE_2) || (idx == IDX_RESET_CAUSE) || (idx == IDX_IRQ_STATUS)
                 || (idx == IDX_IRQ_ENABLE) || (idx == IDX_IRQ_CLEAR) || (idx == IDX_CONFIG);

    always_comb begin
        case (idx)
            IDX_FLAGS_1:     next_rdata = pirs_word(flags_1);
            IDX_FLAGS_2:     next_rdata = pirs_word({7'h00, capcomp2_flag});
            IDX_ENABLE_1:    next_rdata = pirs_word(enable_1);
            IDX_ENABLE_2:    next_rdata = pirs_word({7'h00, capcomp2_enable});
            IDX_RESET_CAUSE: next_rdata = pirs_word({6'h00, cause});
            IDX_IRQ_STATUS:  next_rdata = pirs_word({4'h0, irq_status});
            IDX_IRQ_ENABLE:  next_rdata = pirs_word({4'h0, irq_enable});
            IDX_CONFIG:      next_rdata = pirs_word({7'h00, global_irq_enable});
            default:         next_rdata = 32'h00000000;
        endcase
    end

    assign refuse = !mapped || (pwrite && idx == IDX_IRQ_STATUS);

    // Registered answer: access phase takes two cycles, pready in the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= take;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= take && refuse;
        end
    end

    // Read data only alongside the answer, zero otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= (take && !pwrite) ? next_rdata : 32'h00000000;
        end
    end

    assign next_req = periph_pending && global_irq_enable;
    assign next_irq = |(irq_status & irq_enable);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_irq_req <= 1'b0;
        end else begin
            periph_irq_req <= next_req;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

endmodule // pirs_periph_irq

/* rtl/pirs_pkg.sv */
// Package: register map, field positions and carriers for the peripheral flag block
package pirs_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_FLAGS_1      = 8'h0C;
    localparam logic [7:0]  IDX_FLAGS_2      = 8'h0D;
    localparam logic [7:0]  IDX_ENABLE_2     = 8'h8D;
    localparam logic [7:0]  IDX_RESET_CAUSE  = 8'h8E;
    localparam logic [7:0]  IDX_ENABLE_1     = 8'h8C;
    localparam logic [7:0]  IDX_IRQ_STATUS   = 8'hA0;
    localparam logic [7:0]  IDX_IRQ_ENABLE   = 8'hA1;
    localparam logic [7:0]  IDX_IRQ_CLEAR    = 8'hA2;
    localparam logic [7:0]  IDX_CONFIG       = 8'hA3;

    // Field positions in periph_irq_flags_1
    localparam int BIT_TMR16_OVF   = 0;
    localparam int BIT_PERIOD      = 1;
    localparam int BIT_CAPCOMP1    = 2;
    localparam int BIT_SYNC_SER    = 3;
    localparam int BIT_TX_BUF      = 4;
    localparam int BIT_RX_BUF      = 5;
    localparam int BIT_RESERVED    = 6;
    localparam int BIT_PARALLEL    = 7;

    // Field positions elsewhere
    localparam int BIT_CAPCOMP2    = 0;
    localparam int BIT_BROWNOUT    = 0;
    localparam int BIT_POWERON     = 1;

    // Software-writable mask of flags register 1 (bits 5,4 read-only)
    localparam logic [7:0]  FLAGS_1_WMASK    = 8'hCF;
    localparam logic [7:0]  FLAGS_2_WMASK    = 8'h01;
    localparam logic [7:0]  RESET_CAUSE_MASK = 8'h03;

    // Reset values
    localparam logic [7:0]  FLAGS_RESET      = 8'h00;
    localparam logic [7:0]  ENABLE_RESET     = 8'h00;
    localparam logic [1:0]  CAUSE_RESET      = 2'h0;
    localparam logic [3:0]  IRQ_RESET        = 4'h0;

    // Summary interrupt events: status bit positions
    localparam int EV_FLAGS_1 = 0;
    localparam int EV_FLAGS_2 = 1;
    localparam int EV_BROWNOUT = 2;
    localparam int EV_OVERRUN  = 3;

    typedef enum logic [1:0] {
        PIRS_CC_OFF,
        PIRS_CC_CAPTURE,
        PIRS_CC_COMPARE,
        PIRS_CC_PWM
    } pirs_cc_mode_t;

    // Event strobes from the peripherals, one-cycle pulses in pclk domain
    typedef struct packed {
        logic parallel_done;
        logic sync_serial_done;
        logic capture1;
        logic compare1_match;
        logic timer16_overflow;
        logic capcomp2_event;
    } pirs_events_t;

    // Buffer levels from the USART
    typedef struct packed {
        logic rx_full;
        logic tx_full;
    } pirs_usart_t;

    // Register read helper
    function automatic logic [31:0] pirs_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

endpackage : pirs_pkg

/* bench/pirs_checker.sv */
// Bus-side assertions for the peripheral flag block, bound to its ports
module pirs_checker
    import pirs_pkg::*;
(
    // APB slave side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Pending access phase, answer not yet given
    wire logic acc = psel && penable && !pready;

    AST_ANSWER_NEXT: assert property (acc |=> pready)
        else $error("access phase not answered next cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h00000000)
        else $error("prdata not zero outside an answer");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("prdata upper bits not zero");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("error response without pready or with data");
    AST_UNMAPPED_ERR: assert property (acc && paddr[9:2] == 8'h10 |=> pslverr)
        else $error("unmapped index accepted");
    AST_STATUS_RO: assert property (acc && pwrite && paddr[9:2] == IDX_IRQ_STATUS |=> pslverr)
        else $error("write to status register accepted");
    AST_MAPPED_OK: assert property (acc && (paddr[9:2] == IDX_FLAGS_2 || paddr[9:2] == IDX_ENABLE_2) |=> !pslverr)
        else $error("second flag or enable register refused");
endmodule // pirs_checker

bind pirs_periph_irq pirs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr));

/* bench/pirs_periph_irq_tb.sv */
// Self-checking bench for the peripheral flag block
module pirs_periph_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pirs_pkg::*;

    logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, por_n = 0;
    logic          brownout_reset = 0, brownout_detect_enable = 1;
    logic [11:0]   paddr = '0;
    logic [31:0]   pwdata = '0;
    pirs_events_t  events = '0;
    pirs_usart_t   usart = '0;
    pirs_cc_mode_t capcomp1_mode = PIRS_CC_OFF;
    logic [7:0]    timer8_count = '0, timer8_period = 8'hFF;
    logic          pready, pslverr, periph_irq_req, irq;
    logic [31:0]   prdata;
    logic [8:0]    expq[$];
    logic [15:0]   lfsr = 16'h45F8;
    logic [15:0]   r;
    int            num_errors = 0, checks = 0;
    // Event table: strobe, mode, expected flag byte
    logic [5:0]    ev_t [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h04, 6'h02, 6'h01, 6'h08};
    pirs_cc_mode_t md_t [8] = '{PIRS_CC_OFF, PIRS_CC_OFF, PIRS_CC_CAPTURE, PIRS_CC_COMPARE, PIRS_CC_PWM,
                                PIRS_CC_OFF, PIRS_CC_OFF, PIRS_CC_COMPARE};
    logic [7:0]    fl_t [8] = '{8'h80, 8'h08, 8'h04, 8'h04, 8'h00, 8'h01, 8'h01, 8'h00};

    always #12.5 pclk = ~pclk;

    pirs_periph_irq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .events, .usart, .capcomp1_mode, .timer8_count, .timer8_period, .por_n, .brownout_reset,
        .brownout_detect_enable, .periph_irq_req, .irq);

    function automatic logic [15:0] next_rand();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    task automatic check(string name, logic [8:0] exp, logic [8:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Answers are compared against the oldest note as they appear
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (expq.size() == 0) check("unexpected answer", 9'h1FF, {pslverr, prdata[7:0]});
            else check("prdata", expq.pop_front(), {pslverr, prdata[7:0]});
        end
    end

    // One APB transfer; ends one idle cycle after release so psel is never driven twice per step
    task automatic apb(logic w, logic [7:0] idx, logic [7:0] d, logic [8:0] exp);
        int n;
        n = 0;
        expq.push_back(exp);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk) penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
        @(posedge pclk);
    endtask

    task automatic wr(logic [7:0] idx, logic [7:0] d); apb(1'b1, idx, d, 9'h000); endtask
    task automatic rd(logic [7:0] idx, logic [7:0] e); apb(1'b0, idx, 8'h00, {1'b0, e}); endtask

    task automatic pulse(logic [5:0] e);
        events <= e;
        @(posedge pclk) events <= '0;
        @(posedge pclk);
    endtask

    // Bounded wait for a level output, then compare
    task automatic wait_lvl(string name, bit sel_irq, logic v);
        int n;
        n = 0;
        while ((sel_irq ? irq : periph_irq_req) !== v && n < 10) begin @(posedge pclk); n++; end
        check(name, {8'h00, v}, {8'h00, sel_irq ? irq : periph_irq_req});
        if ((sel_irq ? irq : periph_irq_req) !== v) tally_and_finish();
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        por_n <= 1;
        @(posedge pclk);
        rd(IDX_FLAGS_1, 8'h00);
        rd(IDX_FLAGS_2, 8'h00);
        rd(IDX_ENABLE_2, 8'h00);
        rd(IDX_RESET_CAUSE, 8'h00);
        // Enables all clear here: flags must still set
        for (int i = 0; i < 8; i++) begin
            capcomp1_mode <= md_t[i];
            pulse(ev_t[i]);
            rd(i == 6 ? IDX_FLAGS_2 : IDX_FLAGS_1, fl_t[i]);
            wr(i == 6 ? IDX_FLAGS_2 : IDX_FLAGS_1, 8'h00);
            rd(i == 6 ? IDX_FLAGS_2 : IDX_FLAGS_1, 8'h00);
        end
        timer8_period <= 8'h5A;
        timer8_count <= 8'h5A;
        @(posedge pclk) timer8_count <= 8'h5B;
        @(posedge pclk);
        rd(IDX_FLAGS_1, 8'h02);
        wr(IDX_FLAGS_1, 8'h00);
        usart <= 2'b10;
        repeat (5) @(posedge pclk);
        rd(IDX_FLAGS_1, 8'h20);
        usart <= 2'b01;
        repeat (5) @(posedge pclk);
        rd(IDX_FLAGS_1, 8'h10);
        usart <= 2'b00;
        repeat (5) @(posedge pclk);
        // Bit 6 kept clear by software; read-only bits ignore the write
        r = next_rand();
        wr(IDX_FLAGS_1, (r[7:0] | 8'h30) & 8'hBF);
        rd(IDX_FLAGS_1, r[7:0] & 8'h8F);
        wr(IDX_FLAGS_1, 8'h00);
        wr(IDX_ENABLE_2, 8'h01);
        rd(IDX_ENABLE_2, 8'h01);
        wr(IDX_IRQ_CLEAR, 8'h0F);
        rd(IDX_IRQ_STATUS, 8'h00);
        wr(IDX_ENABLE_1, 8'h01);
        wr(IDX_CONFIG, 8'h01);
        pulse(6'h02);
        wait_lvl("periph_irq_req", 1'b0, 1'b1);
        wait_lvl("irq", 1'b1, 1'b0);
        rd(IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h01);
        wait_lvl("irq", 1'b1, 1'b1);
        wr(IDX_IRQ_CLEAR, 8'h01);
        wait_lvl("irq", 1'b1, 1'b0);
        wr(IDX_FLAGS_1, 8'h00);
        wait_lvl("periph_irq_req", 1'b0, 1'b0);
        apb(1'b1, 8'h10, 8'h55, 9'h100);
        check("pending notes", 9'h000, 9'(expq.size()));
        apb(1'b0, 8'h10, 8'h00, 9'h100);
        apb(1'b1, IDX_IRQ_STATUS, 8'h01, 9'h100);
        wr(IDX_RESET_CAUSE, 8'h03);
        rd(IDX_RESET_CAUSE, 8'h03);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(IDX_RESET_CAUSE, 8'h03);
        brownout_reset <= 1;
        repeat (4) @(posedge pclk);
        brownout_reset <= 0;
        repeat (4) @(posedge pclk);
        rd(IDX_RESET_CAUSE, 8'h02);
        rd(IDX_IRQ_STATUS, 8'h04);
        wr(IDX_RESET_CAUSE, 8'h03);
        por_n <= 0;
        @(posedge pclk) por_n <= 1;
        @(posedge pclk);
        rd(IDX_RESET_CAUSE, 8'h00);
        wr(IDX_RESET_CAUSE, 8'h03);
        brownout_detect_enable <= 0;
        brownout_reset <= 1;
        repeat (4) @(posedge pclk);
        brownout_reset <= 0;
        repeat (4) @(posedge pclk);
        rd(IDX_RESET_CAUSE, 8'h03);
        repeat (2) @(posedge pclk);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        tally_and_finish();
    end
endmodule // pirs_periph_irq_tb
